// ---- memory_block_pkg.sv ----
/*
 * Constants shared by the embedded memory block: register offsets, control
 * field positions, reset values, geometry and operating modes.
 * Assumes nothing of its surroundings; used by scope only, never imported.
 */
package memory_block_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int BLOCK_BITS = 2048;
    localparam int MAX_WIDTH = 16;
    localparam int ADDR_W = 11;
    localparam int PAGE_W = 2;
    localparam logic [2:0] ASPECT_MAX = 3'h4;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] CLEAR_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ASPECT_LSB = 0;
    localparam int CTRL_MODE_LSB = 3;
    localparam int CTRL_OUT_REG_BIT = 5;
    localparam int CTRL_IN_DATA_REG_BIT = 6;
    localparam int CTRL_WR_ADDR_REG_BIT = 7;
    localparam int CTRL_RD_ADDR_REG_BIT = 8;
    localparam int CTRL_WR_EN_REG_BIT = 9;
    localparam int CTRL_RD_EN_REG_BIT = 10;
    localparam int CTRL_PAGE_LSB = 11;
    localparam int CTRL_DEEP_BIT = 13;
    localparam logic [31:0] CTRL_RESET = 32'h000007E0;

    // clear register: write-one pulses
    localparam int CLEAR_WR_BIT = 0;
    localparam int CLEAR_RD_BIT = 1;

    // status register fields
    localparam int STATUS_DRIVE_BIT = 16;
    localparam int STATUS_MODE_LSB = 17;

    // ------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_READ_WRITE = 2'b01,
        MODE_IN_OUT = 2'b10
    } mode_t;

endpackage : memory_block_pkg

// ---- embedded_memory_block.sv ----
/*
 * Embedded memory block: a 2048-bit synchronous RAM with selectable aspect
 * ratio, three clocking modes, optional input and output registers, a
 * self-timed write pulse and a page decoder for a shared output line.
 * Assumes user logic drives the data, address, enable, clear and the two
 * user clock pins from outside this clock domain; software sets the block
 * up over APB with no wait state in any transfer.
 */
// Functional notes
// - depth and width selectable: 128x16, 256x8, 512x4, 1024x2, 2048x1
// - writes go through input registers; output register optional extra stage; here data and write address bypass them when their CTRL bits are clear
// - dual-port mode reads and writes together from two unrelated user clocks
// - internal write strobe is a self-timed pulse from the registered write enable; here the live write enable gates it when CTRL_WR_EN_REG_BIT is clear
// - one block holds 2048 bits; wider memories are blocks side by side
// - deep memories: page decoder drives the output only on its own page
// - deep 8192 words: low eleven address bits to all, two upper to decoders
// - shared output line never driven twice in deep mode, but left floating before the first read and after a read-side clear
// - true two-port read/write memory is built from two or four blocks
// - read/write mode: write clock registers write data, enable and address
// - read/write mode: read clock registers read strobe, address, output data
// - each clock side has its own clock enable and clear
// - input/output mode: input clock registers all data, enables and addresses
// - input/output mode: second clock drives only the output data register
// - input/output mode: input and output registers have separate enables
// - every register clearable by local signal, global signal or chip reset
// - single-port mode shares one address and one clock for reads and writes
// - registering selectable per data in, data out, both addresses, both enables
`timescale 1ns/1ns

module embedded_memory_block (
    input wire logic clock,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // user side, all asynchronous to clock
    input wire logic [15:0] writeData,
    input wire logic [10:0] writeAddr,
    input wire logic [10:0] readAddr,
    input wire logic [1:0] readPage,
    input wire logic writeEnable,
    input wire logic readStrobe,
    input wire logic inClock,
    input wire logic outClock,
    input wire logic inClockEnable,
    input wire logic outClockEnable,
    input wire logic writeSideClear,
    input wire logic readSideClear,
    input wire logic globalClear,
    output logic [15:0] dataOut,
    output logic dataOutOe
);

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    localparam int PIN_W = 49;
    logic [PIN_W-1:0] pinMeta_r;
    logic [PIN_W-1:0] pinSync_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
        end else begin
            pinMeta_r <= {writeData, writeAddr, readAddr, readPage, writeEnable, readStrobe,
                          inClock, outClock, inClockEnable, outClockEnable,
                          writeSideClear, readSideClear, globalClear};
            pinSync_r <= pinMeta_r;
        end
    end

    logic [15:0] wrDataLive;
    logic [10:0] wrAddrLive;
    logic [10:0] rdAddrLive;
    logic [1:0] rdPageLive;
    logic wrEnLive;
    logic rdStrobeLive;
    logic clkASync;
    logic clkBSync;
    logic enASync;
    logic enBSync;
    logic clrWrPin;
    logic clrRdPin;
    logic clrGlobalPin;

    assign {wrDataLive, wrAddrLive, rdAddrLive, rdPageLive, wrEnLive, rdStrobeLive,
            clkASync, clkBSync, enASync, enBSync, clrWrPin, clrRdPin, clrGlobalPin} = pinSync_r;

    // ------------------------------------------------------------
    // user clock edges
    // ------------------------------------------------------------
    logic clkAPrev_r;
    logic clkBPrev_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            clkAPrev_r <= 1'b0;
            clkBPrev_r <= 1'b0;
        end else begin
            clkAPrev_r <= clkASync;
            clkBPrev_r <= clkBSync;
        end
    end

    // ------------------------------------------------------------
    // control register and APB slave
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic swClrWr_r;
    logic swClrRd_r;
    logic [2:0] aspect;
    memory_block_pkg::mode_t mode;
    logic outRegOn;
    logic deepOn;
    logic [1:0] myPage;

    assign aspect = ctrl_r[memory_block_pkg::CTRL_ASPECT_LSB +: 3];
    assign mode = memory_block_pkg::mode_t'(ctrl_r[memory_block_pkg::CTRL_MODE_LSB +: 2]);
    assign outRegOn = ctrl_r[memory_block_pkg::CTRL_OUT_REG_BIT];
    assign deepOn = ctrl_r[memory_block_pkg::CTRL_DEEP_BIT];
    assign myPage = ctrl_r[memory_block_pkg::CTRL_PAGE_LSB +: 2];

    logic apbAccess;
    logic apbWrite;
    logic apbMapped;

    assign apbAccess = psel & penable & pready;
    assign apbWrite = apbAccess & pwrite;
    assign apbMapped = (paddr == memory_block_pkg::CTRL_OFFSET)
                     | (paddr == memory_block_pkg::CLEAR_OFFSET)
                     | (paddr == memory_block_pkg::STATUS_OFFSET);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_r <= memory_block_pkg::CTRL_RESET;
        end else if (apbWrite && paddr == memory_block_pkg::CTRL_OFFSET) begin
            ctrl_r <= pwdata & 32'h00003FFF;
            // unused aspect codes fold onto the narrowest shape
            if (pwdata[2:0] > memory_block_pkg::ASPECT_MAX) begin
                ctrl_r[2:0] <= memory_block_pkg::ASPECT_MAX;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            swClrWr_r <= 1'b0;
            swClrRd_r <= 1'b0;
        end else begin
            swClrWr_r <= apbWrite && paddr == memory_block_pkg::CLEAR_OFFSET
                         && pwdata[memory_block_pkg::CLEAR_WR_BIT];
            swClrRd_r <= apbWrite && paddr == memory_block_pkg::CLEAR_OFFSET
                         && pwdata[memory_block_pkg::CLEAR_RD_BIT];
        end
    end

    // no wait state: ready rises in the access cycle and answers there
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~apbMapped;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                if (paddr == memory_block_pkg::CTRL_OFFSET) begin
                    prdata <= ctrl_r;
                end else if (paddr == memory_block_pkg::STATUS_OFFSET) begin
                    prdata <= {13'h0000, mode, dataOutOe, dataOut};
                end else begin
                    prdata <= '0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // clock routing per mode
    // ------------------------------------------------------------
    logic tickA;
    logic tickB;
    logic readTick;
    logic outTick;
    logic clrWr;
    logic clrRd;

    assign tickA = clkASync & ~clkAPrev_r & enASync;
    assign tickB = clkBSync & ~clkBPrev_r & enBSync;
    // read-side inputs follow the read clock only in read/write mode
    assign readTick = (mode == memory_block_pkg::MODE_READ_WRITE) ? tickB : tickA;
    assign outTick = (mode == memory_block_pkg::MODE_SINGLE) ? tickA : tickB;
    assign clrWr = clrWrPin | clrGlobalPin | swClrWr_r;
    assign clrRd = clrRdPin | clrGlobalPin | swClrRd_r;

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    logic [15:0] wrDataQ_r;
    logic [10:0] wrAddrQ_r;
    logic wrEnQ_r;
    logic wrPend_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wrDataQ_r <= '0;
            wrAddrQ_r <= '0;
            wrEnQ_r <= 1'b0;
            wrPend_r <= 1'b0;
        end else if (clrWr) begin
            wrDataQ_r <= '0;
            wrAddrQ_r <= '0;
            wrEnQ_r <= 1'b0;
            wrPend_r <= 1'b0;
        end else begin
            wrPend_r <= tickA;
            if (tickA) begin
                wrDataQ_r <= wrDataLive;
                wrAddrQ_r <= wrAddrLive;
                wrEnQ_r <= wrEnLive;
            end
        end
    end

    logic [15:0] wrDataUse;
    logic [10:0] wrAddrUse;
    logic wrStrobe;

    assign wrDataUse = ctrl_r[memory_block_pkg::CTRL_IN_DATA_REG_BIT] ? wrDataQ_r : wrDataLive;
    assign wrAddrUse = ctrl_r[memory_block_pkg::CTRL_WR_ADDR_REG_BIT] ? wrAddrQ_r : wrAddrLive;
    // self-timed one-cycle strobe the cycle after the write clock edge
    assign wrStrobe = wrPend_r & (ctrl_r[memory_block_pkg::CTRL_WR_EN_REG_BIT] ? wrEnQ_r
                                                                             : wrEnLive);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic mem [0:memory_block_pkg::BLOCK_BITS-1];
    logic [10:0] wrBase;
    logic [10:0] rdBase;
    logic [4:0] width;
    logic [10:0] addrMask;

    assign width = 5'(memory_block_pkg::MAX_WIDTH >> aspect);
    assign addrMask = 11'((12'h080 << aspect) - 12'h001);
    assign wrBase = 11'((wrAddrUse & addrMask) << (3'h4 - aspect));

    always_ff @(posedge clock) begin
        if (wrStrobe) begin
            for (int i = 0; i < memory_block_pkg::MAX_WIDTH; i++) begin
                if (i < int'(width)) begin
                    mem[11'(wrBase + 11'(i))] <= wrDataUse[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    logic [10:0] rdAddrQ_r;
    logic [1:0] rdPageQ_r;
    logic rdStrobeQ_r;
    logic rdPend_r;
    logic [15:0] rdLatch_r;
    logic pageHit_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdAddrQ_r <= '0;
            rdPageQ_r <= '0;
            rdStrobeQ_r <= 1'b0;
            rdPend_r <= 1'b0;
        end else if (clrRd) begin
            rdAddrQ_r <= '0;
            rdPageQ_r <= '0;
            rdStrobeQ_r <= 1'b0;
            rdPend_r <= 1'b0;
        end else begin
            rdPend_r <= readTick;
            if (readTick) begin
                rdAddrQ_r <= rdAddrLive;
                rdPageQ_r <= rdPageLive;
                rdStrobeQ_r <= rdStrobeLive;
            end
        end
    end

    logic [10:0] rdAddrUse;
    logic [1:0] rdPageUse;
    logic rdStrobeUse;
    logic [15:0] rdWord;

    always_comb begin
        rdAddrUse = ctrl_r[memory_block_pkg::CTRL_RD_ADDR_REG_BIT] ? rdAddrQ_r : rdAddrLive;
        rdPageUse = ctrl_r[memory_block_pkg::CTRL_RD_ADDR_REG_BIT] ? rdPageQ_r : rdPageLive;
        rdStrobeUse = ctrl_r[memory_block_pkg::CTRL_RD_EN_REG_BIT] ? rdStrobeQ_r : rdStrobeLive;
        if (mode == memory_block_pkg::MODE_SINGLE) begin
            rdAddrUse = wrAddrUse;
        end
    end

    assign rdBase = 11'((rdAddrUse & addrMask) << (3'h4 - aspect));

    always_comb begin
        rdWord = '0;
        for (int i = 0; i < memory_block_pkg::MAX_WIDTH; i++) begin
            if (i < int'(width)) begin
                rdWord[i] = mem[11'(rdBase + 11'(i))];
            end
        end
    end

    // a write strobe in the same cycle lands after this sample: old word wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdLatch_r <= '0;
            pageHit_r <= 1'b0;
        end else if (clrRd) begin
            rdLatch_r <= '0;
            pageHit_r <= 1'b0;
        end else if (rdPend_r && rdStrobeUse) begin
            rdLatch_r <= rdWord;
            pageHit_r <= (rdPageUse == myPage);
        end
    end

    // ------------------------------------------------------------
    // output stage and shared-line driver
    // ------------------------------------------------------------
    // bypassed output register still costs one flop: outputs leave from flops
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dataOut <= '0;
        end else if (clrRd) begin
            dataOut <= '0;
        end else if (!outRegOn || outTick) begin
            dataOut <= rdLatch_r;
        end
    end

    // shallow block always drives; deep blocks drive only on their page,
    // and at most one page code matches a read, so no fight, but the line floats before a read and after a read-side clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dataOutOe <= 1'b1;
        end else begin
            dataOutOe <= ~deepOn | pageHit_r;
        end
    end

endmodule : embedded_memory_block

// ---- memory_block_checker.sv ----
/*
 * Checker for the memory block top: APB answers and user-side outputs.
 * Assumes CTRL changes only through APB writes seen on these ports.
 */
`timescale 1ns/1ns
module memory_block_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic readSideClear,
    input wire logic globalClear,
    input wire logic [15:0] dataOut,
    input wire logic dataOutOe
);
    logic [31:0] ctrlCopy_r;
    logic [2:0] aspect;
    logic rdTake;
    assign aspect = (ctrlCopy_r[2:0] > 3'h4) ? 3'h4 : ctrlCopy_r[2:0];
    assign rdTake = pready && !pwrite;
    // shadow of CTRL so width and drive rules can be judged from the pins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) ctrlCopy_r <= memory_block_pkg::CTRL_RESET;
        else if (psel && penable && pready && pwrite && paddr == 12'h000) ctrlCopy_r <= pwdata;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
    a_answer: assert property (p_answer) else $error("apb answer late");
    property p_refuse; pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008});
    endproperty
    a_refuse: assert property (p_refuse) else $error("slverr wrong");
    property p_reset; $fell(reset) |-> dataOut == 16'h0 && dataOutOe && !pready; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_clear; (readSideClear || globalClear) [*6] |-> dataOut == 16'h0; endproperty
    a_clear: assert property (p_clear) else $error("read side not cleared");
    property p_width; !$stable(dataOut) |-> (dataOut >> (16 >> aspect)) == 16'h0; endproperty
    a_width: assert property (p_width) else $error("bits above width");
    property p_oe; !ctrlCopy_r[13] [*3] |-> dataOutOe; endproperty
    a_oe: assert property (p_oe) else $error("shallow block not driving");
    property p_status; rdTake && paddr == 12'h008 |-> prdata[15:0] == $past(dataOut)
        && prdata[16] == $past(dataOutOe) && prdata[18:17] == ctrlCopy_r[4:3];
    endproperty
    a_status: assert property (p_status) else $error("status mismatch");
    property p_ctrl; rdTake && paddr == 12'h000 |-> prdata[31:14] == 18'h0
        && prdata[13:3] == ctrlCopy_r[13:3] && prdata[2:0] == aspect;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl readback wrong");
endmodule : memory_block_checker

bind embedded_memory_block memory_block_checker chk_u (
    .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .readSideClear, .globalClear, .dataOut, .dataOutOe
);

// ---- user_logic_model.sv ----
/*
 * Fabric-side user logic: words, addresses, strobes, user clocks, enables
 * and clears. Assumes the system clock; user clocks rest low between uses.
 */
`timescale 1ns/1ns
module user_logic_model (
    input wire logic clock,
    output logic [15:0] writeData,
    output logic [10:0] writeAddr,
    output logic [10:0] readAddr,
    output logic [1:0] readPage,
    output logic writeEnable,
    output logic readStrobe,
    output logic inClock,
    output logic outClock,
    output logic inClockEnable,
    output logic outClockEnable,
    output logic writeSideClear,
    output logic readSideClear,
    output logic globalClear
);
    initial begin
        {writeData, writeAddr, readAddr, readPage} = '0;
        {writeEnable, readStrobe, inClock, outClock, inClockEnable, outClockEnable} = '0;
        {writeSideClear, readSideClear, globalClear} = '0;
    end
    // phases of 5 system clocks: the pin sampler needs 2
    task automatic xfer(input logic [1:0] s, input logic [10:0] wa, input logic [15:0] wd,
        input logic [10:0] ra, input logic [1:0] pg, input logic [1:0] c, input logic [1:0] e);
        @(posedge clock);
        {writeEnable, readStrobe, writeAddr, writeData, readAddr} <= {s, wa, wd, ra};
        {readPage, inClockEnable, outClockEnable} <= {pg, e};
        repeat (5) @(posedge clock);
        {inClock, outClock} <= c;
        repeat (5) @(posedge clock);
        {inClock, outClock} <= 2'b00;
        repeat (5) @(posedge clock);
        // released lines flip so a stale value cannot pass
        {writeEnable, readStrobe} <= 2'b00;
        {writeAddr, writeData, readAddr, readPage} <= ~{wa, wd, ra, pg};
        repeat (5) @(posedge clock);
    endtask : xfer
    task automatic clr(input logic [2:0] w);
        @(posedge clock);
        {writeSideClear, readSideClear, globalClear} <= w;
        repeat (8) @(posedge clock);
        {writeSideClear, readSideClear, globalClear} <= 3'h0;
        repeat (4) @(posedge clock);
    endtask : clr
endmodule : user_logic_model

// ---- tb_embedded_dual_port_ram_block.sv ----
/*
 * Self-checking bench for the memory block; user results come back via STATUS.
 * Assumes the fabric model and the bound checker.
 */
`timescale 1ns/1ns
module tb_embedded_dual_port_ram_block;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] writeData, dataOut, d, old;
    logic [16:0] m;
    logic [10:0] writeAddr, readAddr;
    logic [1:0] readPage;
    logic writeEnable, readStrobe, inClock, outClock, inClockEnable, outClockEnable;
    logic writeSideClear, readSideClear, globalClear, dataOutOe, pready, pslverr;
    logic [32:0] expQ[$], note;
    int n_errors = 0, tests_run = 0, cycles = 0;
    always #5 clock = ~clock;
    embedded_memory_block dut_u (
        .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .writeData, .writeAddr, .readAddr, .readPage, .writeEnable,
        .readStrobe, .inClock, .outClock, .inClockEnable, .outClockEnable,
        .writeSideClear, .readSideClear, .globalClear, .dataOut, .dataOutOe
    );
    user_logic_model user_u (
        .clock, .writeData, .writeAddr, .readAddr, .readPage, .writeEnable, .readStrobe,
        .inClock, .outClock, .inClockEnable, .outClockEnable, .writeSideClear,
        .readSideClear, .globalClear
    );
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // the sequence needs about 720 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            end_of_test();
        end
    end
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            note = expQ.pop_front();
            tests_run++;
            if ({pslverr, prdata} !== note) begin
                n_errors++;
                $display("[ERR] %0t exp %h got %h", $time, note, {pslverr, prdata});
            end
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    function automatic logic [32:0] st(input logic [1:0] md, input logic oe, input logic [15:0] v);
        return {14'h0, md, oe, v};
    endfunction : st
    task automatic wru(input logic [10:0] a, input logic [15:0] v, input logic [1:0] e);
        user_u.xfer(2'b10, a, v, 11'h0, 2'h0, 2'b10, e);
    endtask : wru
    task automatic rdu(input logic [10:0] a, input logic [1:0] p, input logic [1:0] c,
        input logic [1:0] e);
        user_u.xfer(2'b01, 11'h0, 16'h0, a, p, c, e);
    endtask : rdu
    initial begin
        void'($urandom(32'h819C));
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        rd(12'h000, {1'b0, memory_block_pkg::CTRL_RESET});
        rd(12'h004, 33'h0);
        rd(12'h008, st(2'b00, 1'b1, 16'h0));
        rd(12'h00C, 33'h100000000);
        $display("test reset values done");
        for (int a = 0; a <= 4; a++) begin
            apb(1'b1, 12'h000, 32'h8 | (a[0] ? 32'h7C0 : 32'h0) | 32'(a));
            d = 16'($urandom);
            m = (17'h1 << (16 >> a)) - 17'h1;
            wru(11'h7FF, d, 2'b11);
            rdu(11'((128 << a) - 1), 2'h0, 2'b01, 2'b11);
            rd(12'h008, st(2'b01, 1'b1, d & m[15:0]));
        end
        apb(1'b1, 12'h000, 32'hFFFF07CF);
        rd(12'h000, {1'b0, 32'h000007CC});
        $display("test aspect ratios done");
        apb(1'b1, 12'h000, 32'h000007C8);
        old = 16'($urandom);
        d = ~old;
        wru(11'h5, old, 2'b11);
        user_u.xfer(2'b11, 11'h5, d, 11'h5, 2'h0, 2'b11, 2'b11);
        rd(12'h008, st(2'b01, 1'b1, old));
        wru(11'h5, 16'h0, 2'b01);
        rdu(11'h5, 2'h0, 2'b01, 2'b11);
        rd(12'h008, st(2'b01, 1'b1, d));
        rdu(11'h6, 2'h0, 2'b01, 2'b10);
        rd(12'h008, st(2'b01, 1'b1, d));
        user_u.clr(3'b010);
        rd(12'h008, st(2'b01, 1'b1, 16'h0));
        rdu(11'h5, 2'h0, 2'b01, 2'b11);
        user_u.clr(3'b100);
        rd(12'h008, st(2'b01, 1'b1, d));
        user_u.clr(3'b001);
        rd(12'h008, st(2'b01, 1'b1, 16'h0));
        rdu(11'h5, 2'h0, 2'b01, 2'b11);
        apb(1'b1, 12'h004, 32'h2);
        rd(12'h008, st(2'b01, 1'b1, 16'h0));
        $display("test same address, enables and clears done");
        apb(1'b1, 12'h000, 32'h000007C0);
        d = 16'($urandom);
        wru(11'h9, d, 2'b11);
        user_u.xfer(2'b01, 11'h9, 16'h0, 11'h0, 2'h0, 2'b10, 2'b11);
        rd(12'h008, st(2'b00, 1'b1, d));
        apb(1'b1, 12'h000, 32'h000007F0);
        old = d;
        d = ~old;
        wru(11'h3, d, 2'b11);
        rdu(11'h3, 2'h0, 2'b10, 2'b11);
        rd(12'h008, st(2'b10, 1'b1, old));
        rdu(11'h0, 2'h0, 2'b01, 2'b10);
        rd(12'h008, st(2'b10, 1'b1, old));
        rdu(11'h0, 2'h0, 2'b01, 2'b11);
        rd(12'h008, st(2'b10, 1'b1, d));
        $display("test single and in/out modes done");
        apb(1'b1, 12'h000, 32'h000037C8);
        for (int p = 0; p < 4; p++) begin
            rdu(11'h3, 2'(p), 2'b01, 2'b11);
            rd(12'h008, st(2'b01, p == 2, d));
        end
        $display("test page decode done");
        end_of_test();
    end
endmodule : tb_embedded_dual_port_ram_block
